//--- pkg/pms_cfg.svh
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
// Register map
`define PMS_ADDR_REV 8'h00
`define PMS_ADDR_STAT 8'h01
`define PMS_ADDR_MASK 8'h02
`define PMS_ADDR_LDOV 8'h03
`define PMS_ADDR_CORE 8'h04
`define PMS_MASK_RST 8'hc0
`define PMS_UNMAPPED 8'hff
`define PMS_SLAVE_ADDR 7'h48
// Arbitrary revision value, not tied to any product
`define PMS_REV_VALUE 8'h5a
// Status bit positions
`define PMS_BIT_PFAIL 7
`define PMS_BIT_LBAT 6
`define PMS_BIT_SYS 5
`define PMS_BIT_MEM 4
`define PMS_BIT_CORE 3
`define PMS_BIT_LDOB 2
`define PMS_BIT_LDOA 1
// Core code defaults for the two strap settings
`define PMS_CORE_DEF0 5'h0c
`define PMS_CORE_DEF1 5'h16
// Timing at 200 MHz
`define PMS_CLK_MHZ 200
`define PMS_DEBOUNCE_MS 30
`define PMS_DEBOUNCE_CYC (`PMS_DEBOUNCE_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_RSTDLY_CYC 20000000
`endif

//--- pkg/pms_pkg.sv
package pms_pkg;
   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_WRX, I2C_ACKW, I2C_RDX, I2C_ACKR
   } pms_i2c_state_type;
   typedef logic [7:0] pms_byte_type;
endpackage

//--- rtl/pms_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
// ==========================================
// I2C slave byte engine; bus pins already synchronised
module pms_i2c_slave (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOe,
   output logic wrStb,
   output pms_pkg::pms_byte_type wrAddr,
   output pms_pkg::pms_byte_type wrData,
   output logic rdStb,
   output pms_pkg::pms_byte_type rdAddr,
   input wire pms_pkg::pms_byte_type rdData
);
   typedef struct packed {
      pms_pkg::pms_i2c_state_type st;
      logic sclD;
      logic sdaD;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rnw;
      logic havePtr;
      logic [7:0] ptr;
      logic oe;
      logic wr;
      logic rd;
      logic [7:0] wd;
   } pms_i2c_type;
   pms_i2c_type s_r, s_nxt;
   logic sclRise, sclFall, start, stop;
   // Edges of synchronised pins; wide margin even at 400 kHz
   always_comb begin
      sclRise = s_r.sclD == 1'b0 && sclIn;
      sclFall = s_r.sclD && !sclIn;
      // Data moving while clock high marks start or stop
      start = s_r.sclD && sclIn && s_r.sdaD && !sdaIn;
      stop = s_r.sclD && sclIn && !s_r.sdaD && sdaIn;
   end
   // Protocol walk: shift on rising, drive on falling edges
   always_comb begin
      s_nxt = s_r;
      s_nxt.sclD = sclIn;
      s_nxt.sdaD = sdaIn;
      s_nxt.wr = 1'b0;
      s_nxt.rd = 1'b0;
      if (start) begin
         s_nxt.st = pms_pkg::I2C_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.oe = 1'b0;
         s_nxt.havePtr = 1'b0;
      end else if (stop) begin
         s_nxt.st = pms_pkg::I2C_IDLE;
         s_nxt.oe = 1'b0;
      end else begin
         case (s_r.st)
            pms_pkg::I2C_ADDR, pms_pkg::I2C_WRX: begin
               if (sclRise) begin
                  s_nxt.sh = {s_r.sh[6:0], sdaIn};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end
               if (sclFall && s_r.cnt == 4'h8) begin
                  s_nxt.cnt = 4'h0;
                  if (s_r.st == pms_pkg::I2C_ADDR) begin
                     // Only our own address is answered
                     if (s_r.sh[7:1] == `PMS_SLAVE_ADDR) begin
                        s_nxt.st = pms_pkg::I2C_ACKA;
                        s_nxt.rnw = s_r.sh[0];
                        s_nxt.oe = 1'b1;
                     end else begin
                        s_nxt.st = pms_pkg::I2C_IDLE;
                     end
                  end else begin
                     s_nxt.st = pms_pkg::I2C_ACKW;
                     s_nxt.oe = 1'b1;
                     if (!s_r.havePtr) begin
                        s_nxt.ptr = s_r.sh;
                        s_nxt.havePtr = 1'b1;
                     end else begin
                        s_nxt.wr = 1'b1;
                        s_nxt.wd = s_r.sh;
                     end
                  end
               end
            end
            pms_pkg::I2C_ACKA, pms_pkg::I2C_ACKW: begin
               // Ack held low through the ninth pulse high phase
               if (sclFall) begin
                  if (s_r.st == pms_pkg::I2C_ACKW && s_r.wr == 1'b0
                      && s_r.havePtr && s_r.cnt == 4'h0) begin
                     s_nxt.ptr = s_r.ptr;
                  end
                  if (s_r.st == pms_pkg::I2C_ACKA && s_r.rnw) begin
                     s_nxt.st = pms_pkg::I2C_RDX;
                     s_nxt.sh = rdData;
                     s_nxt.rd = 1'b1;
                     s_nxt.oe = !rdData[7];
                     s_nxt.cnt = 4'h1;
                  end else begin
                     s_nxt.st = pms_pkg::I2C_WRX;
                     s_nxt.oe = 1'b0;
                  end
               end
            end
            pms_pkg::I2C_RDX: begin
               if (sclFall) begin
                  if (s_r.cnt == 4'h8) begin
                     s_nxt.st = pms_pkg::I2C_ACKR;
                     s_nxt.oe = 1'b0;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end else begin
                     s_nxt.oe = !s_r.sh[7 - s_r.cnt[2:0]];
                     s_nxt.cnt = s_r.cnt + 4'h1;
                  end
               end
            end
            pms_pkg::I2C_ACKR: begin
               // Master ack samples here; nack leaves line released
               if (sclRise) begin
                  s_nxt.rnw = !sdaIn;
               end
               if (sclFall) begin
                  if (s_r.rnw) begin
                     s_nxt.st = pms_pkg::I2C_RDX;
                     s_nxt.sh = rdData;
                     s_nxt.rd = 1'b1;
                     s_nxt.oe = !rdData[7];
                     s_nxt.cnt = 4'h1;
                  end else begin
                     s_nxt.st = pms_pkg::I2C_IDLE;
                  end
               end
            end
            default: s_nxt.oe = 1'b0;
         endcase
      end
      // Write pointer advances after each data byte
      if (s_r.wr) begin
         s_nxt.ptr = s_r.ptr + 8'h01;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '{st: pms_pkg::I2C_IDLE, sclD: 1'b1, sdaD: 1'b1,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign sdaOe = s_r.oe;
   assign wrStb = s_r.wr;
   assign wrAddr = s_r.ptr;
   assign wrData = s_r.wd;
   assign rdStb = s_r.rd;
   assign rdAddr = s_r.ptr;
endmodule
`default_nettype wire

//--- rtl/pms_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
module pms_supervisor #(
   parameter int DEBOUNCE_CYC = `PMS_DEBOUNCE_CYC,
   parameter int RSTDLY_CYC = `PMS_RSTDLY_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rtcSupplyGood,
   input wire logic warmResetInN,
   input wire logic coreDefaultSelect,
   input wire logic ldoDefaultSelA,
   input wire logic ldoDefaultSelB,
   input wire logic systemConvEn,
   input wire logic coreConvEn,
   input wire logic memoryConvEn,
   input wire logic ldoEn,
   input wire logic powerFailSense,
   input wire logic lowBatterySense,
   input wire logic [4:0] railLow,
   input wire logic coreScaling,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic systemResetOut,
   output logic systemResetOe,
   output logic interruptOutN,
   output logic [4:0] coreCode,
   output logic [1:0] ldoSelA,
   output logic [1:0] ldoSelB
);
   // Counters need two cycles at least to tell a pulse from a level
   if (DEBOUNCE_CYC < 2 || RSTDLY_CYC < 2) begin : gBadCounts
      $error("pms_supervisor: counts too small");
   end
   // ==========================================
   // Pin synchronisers
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] rawIn, syncOut;
   assign rawIn = {sclIn, sdaIn, warmResetInN, rtcSupplyGood,
                   powerFailSense, lowBatterySense};
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : gSync
         pms_sync uSync (
            .clk_sys(clk_sys),
            .rst(rst),
            .din(rawIn[g]),
            .dout(syncOut[g])
         );
      end
   endgenerate
   logic sclS, sdaS, warmNS, rtcS, pfS, lbS;
   assign {sclS, sdaS, warmNS, rtcS, pfS, lbS} = syncOut;
   // ==========================================
   // Serial slave
   logic wrStb, rdStb;
   pms_pkg::pms_byte_type wrAddr, wrData, rdAddr, rdData;
   pms_i2c_slave uI2c (
      .clk_sys(clk_sys),
      .rst(rst),
      .sclIn(sclS),
      .sdaIn(sdaS),
      .sdaOe(sdaOe),
      .wrStb(wrStb),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .rdStb(rdStb),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );
   // Open-drain data: low only when enabled
   assign sdaOut = 1'b0;
   // ==========================================
   // State
   typedef struct packed {
      logic [31:0] deb;
      logic warmAct;
      logic [31:0] dly;
      logic resAct;
      logic [7:0] mask;
      logic [7:0] block;
      logic [4:0] core;
      logic sysEnD;
      logic latched;
      logic [1:0] ldoA;
      logic [1:0] ldoB;
   } pms_sup_type;
   pms_sup_type s_r, s_nxt;
   pms_pkg::pms_byte_type status;
   logic [4:0] coreDef;
   logic [4:0] enables;
   // Status composition with disabled rails reading good
   always_comb begin
      enables = {systemConvEn, memoryConvEn, coreConvEn, ldoEn, ldoEn};
      status = 8'h00;
      status[`PMS_BIT_PFAIL] = pfS;
      status[`PMS_BIT_LBAT] = lbS;
      status[5:1] = railLow & enables;
      if (coreScaling) begin
         status[`PMS_BIT_CORE] = 1'b0;
      end
      coreDef = coreDefaultSelect ? `PMS_CORE_DEF1 : `PMS_CORE_DEF0;
   end
   // Register read decode
   always_comb begin
      if (rdAddr == `PMS_ADDR_REV) begin
         rdData = `PMS_REV_VALUE;
      end else if (rdAddr == `PMS_ADDR_STAT) begin
         rdData = status;
      end else if (rdAddr == `PMS_ADDR_MASK) begin
         rdData = s_r.mask;
      end else if (rdAddr == `PMS_ADDR_LDOV) begin
         rdData = {4'h0, s_r.ldoB, s_r.ldoA};
      end else if (rdAddr == `PMS_ADDR_CORE) begin
         rdData = {3'h0, s_r.core};
      end else begin
         rdData = `PMS_UNMAPPED;
      end
   end
   // Supervisory next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.sysEnD = systemConvEn;
      // Debounce: level must hold for the whole filter time
      if (warmNS == s_r.warmAct) begin
         if (s_r.deb >= 32'(DEBOUNCE_CYC - 1)) begin
            s_nxt.warmAct = !warmNS;
            s_nxt.deb = 32'h0;
         end else begin
            s_nxt.deb = s_r.deb + 32'h1;
         end
      end else begin
         s_nxt.deb = 32'h0;
      end
      // Reset delay counts only while RTC good and no warm reset
      if (!rtcS || s_r.warmAct) begin
         s_nxt.resAct = 1'b1;
         s_nxt.dly = 32'h0;
      end else if (s_r.resAct) begin
         if (s_r.dly >= 32'(RSTDLY_CYC - 1)) begin
            s_nxt.resAct = 1'b0;
         end else begin
            s_nxt.dly = s_r.dly + 32'h1;
         end
      end
      // One-time strap capture after lockout release
      if (!s_r.latched) begin
         s_nxt.latched = 1'b1;
         s_nxt.ldoA = {ldoDefaultSelB, ldoDefaultSelA};
         s_nxt.ldoB = {ldoDefaultSelB, ldoDefaultSelA};
      end
      // Host writes
      if (wrStb) begin
         if (wrAddr == `PMS_ADDR_MASK) begin
            s_nxt.mask = {wrData[7:1], 1'b0};
         end else if (wrAddr == `PMS_ADDR_LDOV) begin
            s_nxt.ldoA = wrData[1:0];
            s_nxt.ldoB = wrData[3:2];
         end else if (wrAddr == `PMS_ADDR_CORE) begin
            s_nxt.core = wrData[4:0];
         end
      end
      // Forced code when system converter turns off
      if (s_r.sysEnD && !systemConvEn) begin
         s_nxt.core = {1'b1, s_r.core[3:1], 1'b0};
      end
      // Default conditions take priority
      if (s_r.warmAct || !rtcS || s_r.resAct
          || (!coreConvEn && !systemConvEn)) begin
         s_nxt.core = coreDef;
      end
      // Blocking: bits seen at a status read, freed once they clear
      s_nxt.block = s_r.block & status;
      if (rdStb && rdAddr == `PMS_ADDR_STAT) begin
         s_nxt.block = status;
      end
   end
   // Lockout is the only register reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '{mask: `PMS_MASK_RST, resAct: 1'b1, sysEnD: 1'b1,
                  core: `PMS_CORE_DEF0, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
   // ==========================================
   // Outputs
   logic intFault;
   // Power-OK: any unmasked unblocked fault pulls pin low
   assign intFault = |(status & ~s_r.mask & ~s_r.block);
   always_comb begin
      interruptOutN = !intFault;
      systemResetOut = 1'b0;
      systemResetOe = s_r.resAct;
      coreCode = s_r.core;
      ldoSelA = s_r.ldoA;
      ldoSelB = s_r.ldoB;
   end
endmodule
`default_nettype wire

//--- rtl/pms_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-stage synchroniser for one bit
module pms_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_r;
   // First stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_r <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- testbench/pms_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
// ==========================================
// Bus master model; clock stands high between frames
module pms_i2c_host (
   input wire logic sda,
   output logic scl,
   output logic pullSda
);
   logic b;
   initial begin
      scl = 1'b1;
      pullSda = 1'b0;
   end
   // Data moves mid-low and is sampled at the rising clock
   task automatic bitx(input logic d, output logic q);
      #40 pullSda = !d;
      #40 scl = 1'b1;
      q = sda;
      #80 scl = 1'b0;
   endtask
   // Start or repeated start: data falls while clock high
   task automatic start;
      #40 pullSda = 1'b0;
      #40 scl = 1'b1;
      #40 pullSda = 1'b1;
      #40 scl = 1'b0;
   endtask
   // Stop: data rises while clock high, then the bus rests
   task automatic stop;
      #40 pullSda = 1'b1;
      #40 scl = 1'b1;
      #40 pullSda = 1'b0;
      #160;
   endtask
   // Byte MSB first, then the master supplies the ninth pulse
   task automatic xfer(input logic [7:0] d, input logic myAck,
         output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(!myAck, b);
      ack = !b;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
         output logic ok);
      logic [7:0] q;
      logic k;
      start();
      xfer({dev, 1'b0}, 1'b0, q, ok);
      xfer(a, 1'b0, q, k);
      xfer(d, 1'b0, q, k);
      stop();
   endtask
   // Two bytes read; the last is refused so the slave lets go
   task automatic rd(input logic [7:0] a, output logic [7:0] q0, q1);
      logic k;
      start();
      xfer({`PMS_SLAVE_ADDR, 1'b0}, 1'b0, q0, k);
      xfer(a, 1'b0, q0, k);
      start();
      xfer({`PMS_SLAVE_ADDR, 1'b1}, 1'b0, q0, k);
      xfer(8'hff, 1'b1, q0, k);
      xfer(8'hff, 1'b0, q1, k);
      stop();
   endtask
endmodule
`default_nettype wire

//--- testbench/pms_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
// ==========================================
// Port-level checks on the supervisor
module pms_supervisor_asserts #(
   parameter int DEBOUNCE_CYC = 20,
   parameter int RSTDLY_CYC = 30
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rtcSupplyGood,
   input wire logic coreDefaultSelect,
   input wire logic systemConvEn,
   input wire logic coreConvEn,
   input wire logic powerFailSense,
   input wire logic lowBatterySense,
   input wire logic [4:0] railLow,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic systemResetOut,
   input wire logic systemResetOe,
   input wire logic interruptOutN,
   input wire logic [4:0] coreCode
);
   int hiCnt_r;
   logic [4:0] defCode;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   assign defCode = coreDefaultSelect ? `PMS_CORE_DEF1 : `PMS_CORE_DEF0;
   // Length of reset with a good rail; saturates so it never wraps
   always_ff @(posedge clk_sys) begin
      if (rst || !systemResetOe || !rtcSupplyGood)
         hiCnt_r <= 0;
      else if (hiCnt_r < RSTDLY_CYC)
         hiCnt_r <= hiCnt_r + 1;
   end
   // ==========================================
   // Assertions
   a_reset_state: assert property (disable iff (1'b0)
      rst |=> systemResetOe && !sdaOe)
      else $error("reset state wrong");
   a_rst_drain: assert property (systemResetOut == 1'b0)
      else $error("reset pin driven high");
   a_sda_drain: assert property (sdaOut == 1'b0)
      else $error("data pin driven high");
   a_rtc_hold: assert property (!rtcSupplyGood [*4] |-> systemResetOe)
      else $error("reset released with rail low");
   a_release_delay: assert property (
      $fell(systemResetOe) |-> hiCnt_r >= RSTDLY_CYC)
      else $error("reset released early");
   a_core_default: assert property (
      (!rtcSupplyGood || !(systemConvEn || coreConvEn)) [*8]
      |-> coreCode == defCode) else $error("core code not default");
   a_sys_off: assert property (
      (!systemConvEn && coreConvEn && !systemResetOe) [*4]
      |-> coreCode[4] && !coreCode[0]) else $error("core pattern wrong");
   a_int_idle: assert property (
      (railLow == 5'h00 && !powerFailSense && !lowBatterySense) [*6]
      |-> interruptOutN) else $error("interrupt without fault");
   a_ack_low: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("data pulled while clock high");
   c_release: cover property ($fell(systemResetOe));
   c_ack: cover property ($rose(sdaOe));
   c_int: cover property ($fell(interruptOutN));
endmodule

bind pms_supervisor pms_supervisor_asserts #(
   .DEBOUNCE_CYC(DEBOUNCE_CYC), .RSTDLY_CYC(RSTDLY_CYC)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .rtcSupplyGood(rtcSupplyGood),
   .coreDefaultSelect(coreDefaultSelect), .systemConvEn(systemConvEn),
   .coreConvEn(coreConvEn), .powerFailSense(powerFailSense),
   .lowBatterySense(lowBatterySense), .railLow(railLow), .sclIn(sclIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .systemResetOut(systemResetOut),
   .systemResetOe(systemResetOe), .interruptOutN(interruptOutN),
   .coreCode(coreCode));
`default_nettype wire

//--- testbench/pms_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
// ==========================================
// Supervisor bench: pins, straps and register traffic
module pms_supervisor_tb;
   logic clk_sys;
   logic rst = 1'b1, rtcOk = 1'b0, warmN = 1'b1, selA = 1'b1, selB = 1'b0;
   logic sysEn = 1'b1, coreEn = 1'b1, pfs = 1'b0, lbs = 1'b0, dvs = 1'b0;
   logic coreSel = 1'b1;
   logic [4:0] railLow = 5'h00;
   logic pull, scl, ok, sdaOe, rstOut, rstOe, intN;
   wire logic sda;
   logic [4:0] coreCode;
   logic [1:0] ldoA, ldoB;
   logic [7:0] q0, q1;
   int failures, n_checks;
   // Pulled-up data wire
   assign sda = !(sdaOe || pull);
   pms_supervisor #(.DEBOUNCE_CYC(20), .RSTDLY_CYC(30)) u_pms_supervisor (
      .clk_sys(clk_sys), .rst(rst), .rtcSupplyGood(rtcOk),
      .warmResetInN(warmN), .coreDefaultSelect(coreSel),
      .ldoDefaultSelA(selA), .ldoDefaultSelB(selB),
      .systemConvEn(sysEn), .coreConvEn(coreEn),
      .memoryConvEn(1'b1), .ldoEn(1'b1), .powerFailSense(pfs),
      .lowBatterySense(lbs), .railLow(railLow), .coreScaling(dvs),
      .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
      .systemResetOut(rstOut), .systemResetOe(rstOe),
      .interruptOutN(intN), .coreCode(coreCode), .ldoSelA(ldoA),
      .ldoSelB(ldoB));
   pms_i2c_host u_pms_i2c_host (.sda(sda), .scl(scl), .pullSda(pull));
   // ==========================================
   // Helpers
   task automatic chk(input logic [7:0] got, exp, input string m);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Bus calls end on a falling edge so pin changes stay off the edge
   task automatic rd(input logic [7:0] a);
      u_pms_i2c_host.rd(a, q0, q1);
      cyc(1);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, d);
      u_pms_i2c_host.wr(dev, a, d, ok);
      cyc(1);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Watchdog well beyond the expected run of about 97 us
   initial begin
      #300us;
      failures++;
      tally_and_finish();
   end
   // ==========================================
   // Scenarios
   initial begin
      cyc(2);
      rst = 1'b0;
      cyc(50);
      chk(rstOe, 8'h1, "reset with rail low");
      chk({ldoB, ldoA}, 8'h05, "strap latch");
      selA = 1'b0;
      rtcOk = 1'b1;
      cyc(20);
      chk(rstOe, 8'h1, "reset delay");
      cyc(40);
      chk(rstOe, 8'h0, "reset release");
      chk(rstOut, 8'h0, "open drain");
      chk({ldoB, ldoA}, 8'h05, "strap held");
      chk(coreCode, `PMS_CORE_DEF1, "core default");
      rd(8'h00);
      chk(q0, `PMS_REV_VALUE, "revision");
      chk(q1, 8'h00, "status idle");
      wr(`PMS_SLAVE_ADDR, 8'h00, 8'h33);
      chk(ok, 8'h1, "address ack");
      rd(8'h00);
      chk(q0, `PMS_REV_VALUE, "revision write");
      rd(8'h10);
      chk(q0, `PMS_UNMAPPED, "unmapped");
      wr(7'h49, 8'h02, 8'hff);
      chk(ok, 8'h0, "foreign address");
      rd(8'h02);
      chk(q0, `PMS_MASK_RST, "mask reset");
      railLow = 5'h15;
      pfs = 1'b1;
      cyc(8);
      chk(intN, 8'h0, "fault to pin");
      rd(8'h01);
      chk(q0, 8'haa, "status bits");
      chk(intN, 8'h1, "read blocks");
      railLow = 5'h17;
      cyc(8);
      chk(intN, 8'h0, "new fault");
      wr(`PMS_SLAVE_ADDR, 8'h02, 8'hc4);
      chk(intN, 8'h1, "mask");
      lbs = 1'b1;
      dvs = 1'b1;
      cyc(8);
      rd(8'h01);
      chk(q0, 8'he6, "scaling and battery");
      railLow = 5'h00;
      {pfs, lbs, dvs} = 3'h0;
      cyc(8);
      railLow = 5'h01;
      cyc(8);
      chk(intN, 8'h0, "block freed");
      railLow = 5'h00;
      wr(`PMS_SLAVE_ADDR, 8'h03, 8'h0e);
      chk({ldoB, ldoA}, 8'h0e, "ldo override");
      wr(`PMS_SLAVE_ADDR, 8'h04, 8'h0a);
      warmN = 1'b0;
      cyc(10);
      warmN = 1'b1;
      cyc(10);
      chk(rstOe, 8'h0, "glitch ignored");
      chk(coreCode, 8'h0a, "glitch keeps core");
      warmN = 1'b0;
      cyc(40);
      chk(rstOe, 8'h1, "warm reset");
      chk(coreCode, `PMS_CORE_DEF1, "warm core");
      chk({ldoB, ldoA}, 8'h0e, "warm keeps ldo");
      warmN = 1'b1;
      cyc(80);
      chk(rstOe, 8'h0, "warm release");
      wr(`PMS_SLAVE_ADDR, 8'h04, 8'h0a);
      sysEn = 1'b0;
      railLow = 5'h10;
      cyc(8);
      chk(coreCode, 8'h1a, "system off");
      rd(8'h01);
      chk(q0, 8'h00, "disabled rail");
      coreEn = 1'b0;
      cyc(8);
      chk(coreCode, `PMS_CORE_DEF1, "both off");
      {sysEn, coreEn, railLow} = 7'h60;
      wr(`PMS_SLAVE_ADDR, 8'h04, 8'h0a);
      rtcOk = 1'b0;
      cyc(8);
      chk(rstOe, 8'h1, "rail drop");
      chk(coreCode, `PMS_CORE_DEF1, "rail drop core");
      rtcOk = 1'b1;
      coreSel = 1'b0;
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(4);
      chk({ldoB, ldoA}, 8'h00, "strap relatch");
      chk(coreCode, `PMS_CORE_DEF0, "lockout core low");
      rd(8'h02);
      chk(q0, `PMS_MASK_RST, "mask after lockout");
      tally_and_finish();
   end
endmodule
`default_nettype wire
